// [common/clm_pkg.sv]
/*
  shared constants for the channel level meter: command spaces, register
  indices, bit positions, reset values and the measurement interval.
  assumes a single 25 MHz core clock and 16-bit linear samples.
*/
package clm_pkg;
  // ************************************************
  // sizes
  // ************************************************
  localparam int CH_N = 4;
  localparam int DATA_W = 16;
  localparam int THR_W = 8;
  localparam int COEF_W = 16;
  localparam int ACC_W = 32;
  localparam int FILT_Q = 14; // coefficient fraction bits
  // ************************************************
  // timing
  // ************************************************
  localparam int CLK_KHZ = 25000;
  localparam int MEAS_TIME_US = 4000; // one measurement interval
  localparam int MEAS_CYC = MEAS_TIME_US * CLK_KHZ / 1000;
  // ************************************************
  // command spaces and register indices
  // ************************************************
  localparam logic SP_CFG = 1'h0;
  localparam logic SP_EXT = 1'h1;
  localparam logic [2:0] IDX_CR0 = 3'h0;
  localparam logic [2:0] IDX_CR2 = 3'h2;
  localparam logic [2:0] IDX_CR4 = 3'h4;
  localparam logic [2:0] IDX_THR = 3'h7; // level_threshold_register
  // ************************************************
  // fields and reset values
  // ************************************************
  localparam int CR0_HYB_BIT = 0;
  localparam int CR2_VT_BIT = 0;
  localparam int CR2_FLAG_BIT = 1;
  localparam int CR2_LM_BIT = 2;
  localparam int CR4_LOOP_BIT = 0;
  localparam logic [7:0] CR_RST = 8'h00;
  localparam logic [THR_W-1:0] THR_RST = 8'h00;
  // mean-magnitude units per threshold code, about 0.02 Vrms
  localparam logic [15:0] LVL_STEP = 16'h0020;
endpackage

// [common/clm_meter_if.sv]
/*
  carrier between the control logic and one channel meter.
  assumes both ends share the core clock.
*/
`timescale 1ns/1ps
interface clm_meter_if;
  logic en;
  logic stb;
  logic signed [clm_pkg::DATA_W-1:0] sample;
  logic signed [clm_pkg::COEF_W-1:0] coef_a;
  logic signed [clm_pkg::COEF_W-1:0] coef_b;
  logic [clm_pkg::THR_W-1:0] thr;
  logic flag;
  logic valid;
  modport ctl (output en, stb, sample, coef_a, coef_b, thr, input flag, valid);
  modport mtr (input en, stb, sample, coef_a, coef_b, thr, output flag, valid);
endinterface

// [verilog/clm_meter.sv]
/*
  one channel meter: bandpass, rectifier, window accumulator, comparator.
  assumes samples arrive as one-cycle strobes well below the clock rate.
*/
`timescale 1ns/1ps
module clm_meter #(
  parameter int MEAS = clm_pkg::MEAS_CYC
) (
  input wire logic clk,
  input wire logic rst,
  clm_meter_if.mtr m
);
  localparam int YW = clm_pkg::DATA_W + 4;
  localparam int PW = YW + clm_pkg::COEF_W;
  logic signed [YW-1:0] y1_q, y2_q, y_d;
  logic signed [PW-1:0] pa, pb;
  logic [YW-1:0] mag;
  logic [clm_pkg::ACC_W-1:0] acc_q, ns_q, lim;
  logic [31:0] win_q, age_q;
  logic wrap;

  // ************************************************
  // resonator bandpass from tone generator two coefficients
  // ************************************************
  assign pa = m.coef_a * y1_q;
  assign pb = m.coef_b * y2_q;
  always_comb begin
    y_d = YW'(m.sample) + YW'(pa >>> clm_pkg::FILT_Q) - YW'(pb >>> clm_pkg::FILT_Q);
    mag = y_d[YW-1] ? YW'(-y_d) : y_d;
  end

  // filter history, cleared while idle
  always_ff @(posedge clk) begin
    if (rst || !m.en) begin
      y1_q <= '0;
      y2_q <= '0;
    end else if (m.stb) begin
      y1_q <= y_d;
      y2_q <= y1_q;
    end
  end

  // ************************************************
  // interval timer and comparison
  // ************************************************
  assign wrap = (win_q == 32'(MEAS - 1));
  assign lim = clm_pkg::ACC_W'(m.thr * clm_pkg::LVL_STEP * ns_q);
  always_ff @(posedge clk) begin
    if (rst || !m.en) begin
      win_q <= '0;
      acc_q <= '0;
      ns_q <= '0;
      m.flag <= 1'b0;
      m.valid <= 1'b0;
    end else if (wrap) begin
      win_q <= '0;
      acc_q <= '0;
      ns_q <= '0;
      m.flag <= (acc_q > lim);
      m.valid <= 1'b1;
    end else begin
      win_q <= win_q + 32'h1;
      if (m.stb) begin
        acc_q <= acc_q + clm_pkg::ACC_W'(mag);
        ns_q <= ns_q + 32'h1;
      end
    end
  end

  // helper: cycles since enable
  always_ff @(posedge clk) begin
    if (rst || !m.en) age_q <= '0;
    else if (age_q != 32'hffffffff) age_q <= age_q + 32'h1;
  end

  property p_first;
    @(posedge clk) disable iff (rst) $rose(m.valid) |-> age_q == 32'(MEAS);
  endproperty
  a_first: assert property (p_first) else $error("first result not at interval end");
  property p_refresh;
    @(posedge clk) disable iff (rst) (m.en && !$fell(m.en) && $changed(m.flag)) |->
      $past(wrap);
  endproperty
  a_refresh: assert property (p_refresh) else $error("flag moved off interval edge");
  property p_hold;
    @(posedge clk) disable iff (rst) (m.valid && !wrap) |=> $stable(m.flag) || !m.en;
  endproperty
  a_hold: assert property (p_hold) else $error("flag not held between updates");
  property p_rect;
    @(posedge clk) disable iff (rst) (m.en && !wrap && $past(m.en)) |=> acc_q >= $past(acc_q);
  endproperty
  a_rect: assert property (p_rect) else $error("rectified sum decreased");
endmodule

// [verilog/clm_top.sv]
/*
  level meter for a four channel codec: per-channel configuration bits,
  the shared threshold byte, loopback select and one meter per channel.
  assumes the codec core supplies strobed linear samples per channel and
  issues configuration and extended-register commands one per cycle.
*/
// Functional notes
// - bandpass response comes from channel's tone generator two coefficients
// - filtered transmit test signal is rectified and compared with threshold
// - comparison flag is readable in configuration register two
// - one eight-bit threshold shared by all four channels
// - threshold sits at extended register seven via extended command
// - first valid flag appears 4 ms after enable is set
// - flag refreshed every 4 ms from current signal and threshold
// - adjacent threshold codes differ by about 0.02 Vrms
// - setting meter enable turns off tone generator two
// - tone one gives -4.5 dBm0 with gain filters disabled
// - digital loopbacks from config register four feed receive into transmit
// - hybrid balance filter enabled by its bit in config register zero
`timescale 1ns/1ps
module clm_top #(
  parameter int MEAS_CYCLES = clm_pkg::MEAS_CYC,
  parameter int CH = clm_pkg::CH_N
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // register command port
  input wire logic CMD_VALID,
  input wire logic CMD_WRITE,
  input wire logic CMD_SPACE,
  input wire logic [1:0] CMD_CH,
  input wire logic [2:0] CMD_ADDR,
  input wire logic [7:0] CMD_WDATA,
  output logic [7:0] CMD_RDATA,
  output logic CMD_RVALID,
  // tone generator two coefficient load
  input wire logic COEF_WE,
  input wire logic [1:0] COEF_CH,
  input wire logic [2*clm_pkg::COEF_W-1:0] COEF_DATA,
  // sample streams
  input wire logic SAMPLE_STB,
  input wire logic [CH*clm_pkg::DATA_W-1:0] TX_SAMPLE,
  input wire logic [CH*clm_pkg::DATA_W-1:0] RX_SAMPLE,
  // per-channel controls toward the codec core
  input wire logic [CH-1:0] TG2_REQ,
  output logic [CH-1:0] TG2_RUN,
  output logic [CH-1:0] HYB_EN,
  output logic [CH-1:0] VOICE_PLUS_TONE,
  output logic [CH-1:0] LOOP_EN
);
  logic [7:0] cr0_q [CH];
  logic [7:0] cr2_q [CH];
  logic [7:0] cr4_q [CH];
  logic [clm_pkg::THR_W-1:0] thr_q;
  logic [2*clm_pkg::COEF_W-1:0] coef_q [CH];
  logic [CH-1:0] flag_w, valid_w;
  logic [7:0] rd_d;
  logic wr_cfg, wr_ext;

  // decodes one configuration index into a write strobe
  function automatic logic cfg_hit(input logic [2:0] idx);
    cfg_hit = CMD_VALID && CMD_WRITE && (CMD_SPACE == clm_pkg::SP_CFG) && (CMD_ADDR == idx);
  endfunction

  // ************************************************
  // command decode
  // ************************************************
  assign wr_cfg = CMD_VALID && CMD_WRITE && (CMD_SPACE == clm_pkg::SP_CFG);
  assign wr_ext = CMD_VALID && CMD_WRITE && (CMD_SPACE == clm_pkg::SP_EXT) &&
                  (CMD_ADDR == clm_pkg::IDX_THR);

  // shared threshold byte, one copy for every channel
  always_ff @(posedge CLK) begin
    if (RST) thr_q <= clm_pkg::THR_RST;
    else if (wr_ext) thr_q <= CMD_WDATA;
  end

  // ************************************************
  // per-channel registers and meters
  // ************************************************
  generate
    for (genvar c = 0; c < CH; c++) begin : g_ch
      clm_meter_if mif ();
      logic sel;
      assign sel = (CMD_CH == 2'(c));

      // configuration registers of this channel
      always_ff @(posedge CLK) begin
        if (RST) begin
          cr0_q[c] <= clm_pkg::CR_RST;
          cr2_q[c] <= clm_pkg::CR_RST;
          cr4_q[c] <= clm_pkg::CR_RST;
        end else if (sel) begin
          if (cfg_hit(clm_pkg::IDX_CR0)) cr0_q[c] <= CMD_WDATA;
          if (cfg_hit(clm_pkg::IDX_CR2)) cr2_q[c] <= CMD_WDATA;
          if (cfg_hit(clm_pkg::IDX_CR4)) cr4_q[c] <= CMD_WDATA;
        end
      end

      // tone generator two coefficients, also the meter bandpass
      always_ff @(posedge CLK) begin
        if (RST) coef_q[c] <= '0;
        else if (COEF_WE && COEF_CH == 2'(c)) coef_q[c] <= COEF_DATA;
      end

      // controls toward the core
      assign HYB_EN[c] = cr0_q[c][clm_pkg::CR0_HYB_BIT];
      assign LOOP_EN[c] = cr4_q[c][clm_pkg::CR4_LOOP_BIT];
      assign VOICE_PLUS_TONE[c] = cr2_q[c][clm_pkg::CR2_VT_BIT];
      assign TG2_RUN[c] = TG2_REQ[c] && !cr2_q[c][clm_pkg::CR2_LM_BIT];

      // tone one level is set upstream and reaches the meter as samples
      // meter feed: loopback returns the receive stream into transmit
      assign mif.en = cr2_q[c][clm_pkg::CR2_LM_BIT];
      assign mif.stb = SAMPLE_STB;
      assign mif.sample = LOOP_EN[c] ? RX_SAMPLE[c*clm_pkg::DATA_W +: clm_pkg::DATA_W]
                                     : TX_SAMPLE[c*clm_pkg::DATA_W +: clm_pkg::DATA_W];
      assign mif.coef_a = coef_q[c][clm_pkg::COEF_W +: clm_pkg::COEF_W];
      assign mif.coef_b = coef_q[c][0 +: clm_pkg::COEF_W];
      assign mif.thr = thr_q;
      assign flag_w[c] = mif.flag;
      assign valid_w[c] = mif.valid;

      clm_meter #(.MEAS(MEAS_CYCLES)) u_meter (
        .clk(CLK),
        .rst(RST),
        .m(mif)
      );

      property p_loop;
        @(posedge CLK) disable iff (RST) LOOP_EN[c] |->
          mif.sample == RX_SAMPLE[c*clm_pkg::DATA_W +: clm_pkg::DATA_W];
      endproperty
      a_loop: assert property (p_loop) else $error("loopback not selected");
      property p_tg2_off;
        @(posedge CLK) disable iff (RST) mif.en |-> !TG2_RUN[c];
      endproperty
      a_tg2_off: assert property (p_tg2_off) else $error("tone two runs while metering");
      property p_hyb;
        @(posedge CLK) disable iff (RST) (sel && cfg_hit(clm_pkg::IDX_CR0)) |=>
          HYB_EN[c] == $past(CMD_WDATA[clm_pkg::CR0_HYB_BIT]);
      endproperty
      a_hyb: assert property (p_hyb) else $error("hybrid enable not following bit");
      property p_thr_feed;
        @(posedge CLK) disable iff (RST) wr_ext |=> mif.thr == $past(CMD_WDATA);
      endproperty
      a_thr_feed: assert property (p_thr_feed) else $error("channel threshold differs");
    end
  endgenerate

  // ************************************************
  // read path
  // ************************************************
  always_comb begin
    rd_d = 8'h00;
    if (CMD_SPACE == clm_pkg::SP_EXT) begin
      if (CMD_ADDR == clm_pkg::IDX_THR) rd_d = thr_q;
    end else begin
      case (CMD_ADDR)
        clm_pkg::IDX_CR0: rd_d = cr0_q[CMD_CH];
        clm_pkg::IDX_CR2: begin
          rd_d = cr2_q[CMD_CH];
          rd_d[clm_pkg::CR2_FLAG_BIT] = flag_w[CMD_CH] && valid_w[CMD_CH];
        end
        clm_pkg::IDX_CR4: rd_d = cr4_q[CMD_CH];
        default: rd_d = 8'h00;
      endcase
    end
  end

  // registered read answer, one cycle after the request
  always_ff @(posedge CLK) begin
    if (RST) begin
      CMD_RDATA <= 8'h00;
      CMD_RVALID <= 1'b0;
    end else begin
      CMD_RVALID <= CMD_VALID && !CMD_WRITE;
      if (CMD_VALID && !CMD_WRITE) CMD_RDATA <= rd_d;
    end
  end

  // ************************************************
  // checks
  // ************************************************
  sequence s_thr_wr;
    wr_ext;
  endsequence
  sequence s_cr2_rd;
    CMD_VALID && !CMD_WRITE && CMD_SPACE == clm_pkg::SP_CFG && CMD_ADDR == clm_pkg::IDX_CR2;
  endsequence
  property p_thr_wr;
    @(posedge CLK) disable iff (RST) s_thr_wr |=> thr_q == $past(CMD_WDATA);
  endproperty
  a_thr_wr: assert property (p_thr_wr) else $error("threshold write lost");
  property p_flag_rd;
    @(posedge CLK) disable iff (RST) s_cr2_rd |=> CMD_RVALID &&
      CMD_RDATA[clm_pkg::CR2_FLAG_BIT] == $past(flag_w[CMD_CH] && valid_w[CMD_CH]);
  endproperty
  a_flag_rd: assert property (p_flag_rd) else $error("flag read mismatch");
  property p_hidden;
    @(posedge CLK) disable iff (RST) (s_cr2_rd and !valid_w[CMD_CH]) |=>
      !CMD_RDATA[clm_pkg::CR2_FLAG_BIT];
  endproperty
  a_hidden: assert property (p_hidden) else $error("flag shown before first interval");
  property p_cfg_no_thr;
    @(posedge CLK) disable iff (RST) (wr_cfg && !wr_ext) |=> $stable(thr_q);
  endproperty
  a_cfg_no_thr: assert property (p_cfg_no_thr) else $error("threshold hit by config write");
endmodule

// [tb/clm_top_tb.sv]
/*
  self-checking bench for the channel level meter top: reset values, register
  access, meter enable side effects, flag timing and loopback metering.
  assumes the design package is compiled first and a short meter interval.
*/
`timescale 1ns/1ps
module clm_top_tb;
  // ************************************************
  // clock, reset and design inputs
  // ************************************************
  localparam int MEAS = 64;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_write = 1'b0;
  logic cmd_space = 1'b0;
  logic [1:0] cmd_ch = 2'h0;
  logic [2:0] cmd_addr = 3'h0;
  logic [7:0] cmd_wdata = 8'h00;
  logic coef_we = 1'b0;
  logic [1:0] coef_ch = 2'h0;
  logic [31:0] coef_data = 32'h0000_0000;
  logic sample_stb = 1'b0;
  logic [63:0] tx_sample = 64'h0100_0000_0100_0100; // held constant
  logic [63:0] rx_sample = 64'h0000_0100_0000_0000;
  logic [3:0] tg2_req = 4'hf;
  logic [7:0] rdata;
  logic rvalid;
  logic [3:0] tg2_run, hyb_en, vpt, loop_en;
  logic [7:0] got;
  int fails = 0;
  int check_count = 0;
  int cyc = 0;
  int stb_cnt = 0;

  // ************************************************
  // design under test
  // ************************************************
  clm_top #(.MEAS_CYCLES(MEAS), .CH(4)) dut_u (
    .CLK(clk), .RST(rst),
    .CMD_VALID(cmd_valid), .CMD_WRITE(cmd_write), .CMD_SPACE(cmd_space),
    .CMD_CH(cmd_ch), .CMD_ADDR(cmd_addr), .CMD_WDATA(cmd_wdata),
    .CMD_RDATA(rdata), .CMD_RVALID(rvalid),
    .COEF_WE(coef_we), .COEF_CH(coef_ch), .COEF_DATA(coef_data),
    .SAMPLE_STB(sample_stb), .TX_SAMPLE(tx_sample), .RX_SAMPLE(rx_sample),
    .TG2_REQ(tg2_req), .TG2_RUN(tg2_run), .HYB_EN(hyb_en),
    .VOICE_PLUS_TONE(vpt), .LOOP_EN(loop_en)
  );

  // clock, sample strobe every fourth cycle, and hang guard
  always #20 clk = ~clk;
  always @(negedge clk) begin
    stb_cnt <= (stb_cnt + 1) % 4;
    sample_stb <= (stb_cnt == 0);
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      conclude();
    end
  end

  // ************************************************
  // shared tasks
  // ************************************************
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    check_count = check_count + 1;
    if (g !== e) begin
      fails = fails + 1;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic sp, input logic [1:0] ch, input logic [2:0] a,
                    input logic [7:0] d);
    cmd_valid = 1'b1;
    cmd_write = 1'b1;
    cmd_space = sp;
    cmd_ch = ch;
    cmd_addr = a;
    cmd_wdata = d;
    @(negedge clk);
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    @(negedge clk); // idle cycle before the next request
  endtask

  // read answer is sampled at the falling edge, half a cycle after the taking edge
  task automatic rd(input logic sp, input logic [1:0] ch, input logic [2:0] a);
    cmd_valid = 1'b1;
    cmd_write = 1'b0;
    cmd_space = sp;
    cmd_ch = ch;
    cmd_addr = a;
    @(negedge clk);
    cmd_valid = 1'b0;
    chk({7'h00, rvalid}, 8'h01);
    got = rdata;
    @(negedge clk); // idle cycle before the next request
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // ************************************************
  // scenarios
  // ************************************************
  task automatic t_reset();
    for (int c = 0; c < 4; c++) begin
      rd(clm_pkg::SP_CFG, c[1:0], clm_pkg::IDX_CR0);
      chk(got, clm_pkg::CR_RST);
      rd(clm_pkg::SP_CFG, c[1:0], clm_pkg::IDX_CR2);
      chk(got, clm_pkg::CR_RST);
      rd(clm_pkg::SP_CFG, c[1:0], clm_pkg::IDX_CR4);
      chk(got, clm_pkg::CR_RST);
    end
    rd(clm_pkg::SP_EXT, 2'h0, clm_pkg::IDX_THR);
    chk(got, clm_pkg::THR_RST);
    chk({4'h0, tg2_run}, 8'h0f);
    chk({hyb_en, loop_en}, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_regs();
    wr(clm_pkg::SP_CFG, 2'h1, clm_pkg::IDX_CR0, 8'h01);
    wr(clm_pkg::SP_CFG, 2'h3, clm_pkg::IDX_CR4, 8'h01);
    wr(clm_pkg::SP_CFG, 2'h2, clm_pkg::IDX_CR2, 8'h01);
    chk({4'h0, hyb_en}, 8'h02);
    chk({4'h0, loop_en}, 8'h08);
    chk({4'h0, vpt}, 8'h04);
    wr(clm_pkg::SP_EXT, 2'h1, clm_pkg::IDX_THR, 8'h5a);
    wr(clm_pkg::SP_EXT, 2'h0, 3'h3, 8'hff);
    rd(clm_pkg::SP_EXT, 2'h3, clm_pkg::IDX_THR);
    chk(got, 8'h5a);
    rd(clm_pkg::SP_EXT, 2'h0, 3'h3);
    chk(got, 8'h00);
    wr(clm_pkg::SP_CFG, 2'h1, clm_pkg::IDX_CR0, 8'h00);
    wr(clm_pkg::SP_CFG, 2'h3, clm_pkg::IDX_CR4, 8'h00);
    wr(clm_pkg::SP_CFG, 2'h2, clm_pkg::IDX_CR2, 8'h00);
    chk({hyb_en, vpt}, 8'h00);
    $display("test registers done");
  endtask

  // constant 0x100 input: mean 256, codes 7 and 9 lie either side
  task automatic t_meter();
    coef_we = 1'b1;
    coef_ch = 2'h0;
    @(negedge clk);
    coef_we = 1'b0;
    wr(clm_pkg::SP_EXT, 2'h0, clm_pkg::IDX_THR, 8'h07);
    wr(clm_pkg::SP_CFG, 2'h0, clm_pkg::IDX_CR2, 8'h06); // voice off
    chk({4'h0, tg2_run}, 8'h0e);
    wait_cyc(MEAS / 2);
    rd(clm_pkg::SP_CFG, 2'h0, clm_pkg::IDX_CR2);
    chk(got, 8'h04);
    wait_cyc(2 * MEAS);
    rd(clm_pkg::SP_CFG, 2'h0, clm_pkg::IDX_CR2);
    chk(got, 8'h06);
    wr(clm_pkg::SP_EXT, 2'h0, clm_pkg::IDX_THR, 8'h09);
    wait_cyc(2 * MEAS + 8);
    rd(clm_pkg::SP_CFG, 2'h0, clm_pkg::IDX_CR2);
    chk(got, 8'h04);
    wr(clm_pkg::SP_CFG, 2'h0, clm_pkg::IDX_CR2, 8'h00);
    rd(clm_pkg::SP_CFG, 2'h0, clm_pkg::IDX_CR2);
    chk(got, 8'h00);
    chk({4'h0, tg2_run}, 8'h0f);
    $display("test meter done");
  endtask

  // channel two sees silence on transmit, level only via the loop
  task automatic t_loop();
    wr(clm_pkg::SP_EXT, 2'h0, clm_pkg::IDX_THR, 8'h07);
    wr(clm_pkg::SP_CFG, 2'h2, clm_pkg::IDX_CR0, 8'h00); // hybrid off
    wr(clm_pkg::SP_CFG, 2'h2, clm_pkg::IDX_CR4, 8'h01);
    wr(clm_pkg::SP_CFG, 2'h2, clm_pkg::IDX_CR2, 8'h04); // voice off
    wait_cyc(2 * MEAS + 8); // level changed by the loop
    rd(clm_pkg::SP_CFG, 2'h2, clm_pkg::IDX_CR2);
    chk(got, 8'h06);
    rd(clm_pkg::SP_CFG, 2'h0, clm_pkg::IDX_CR2);
    chk(got, 8'h00);
    $display("test loop done");
  endtask

  // bisection on channel zero: level 0x100 over step 0x20 is code 8
  task automatic t_search();
    logic [7:0] lo;
    logic [7:0] hi;
    logic [7:0] mid;
    lo = 8'h00;
    hi = 8'hff;
    wr(clm_pkg::SP_CFG, 2'h0, clm_pkg::IDX_CR2, 8'h04); // voice off
    while (hi - lo > 8'h01) begin
      mid = lo + (hi - lo) / 2; // starts mid-range
      wr(clm_pkg::SP_EXT, 2'h0, clm_pkg::IDX_THR, mid);
      wait_cyc(MEAS + 8);
      rd(clm_pkg::SP_CFG, 2'h0, clm_pkg::IDX_CR2);
      if (got[clm_pkg::CR2_FLAG_BIT]) begin
        lo = mid;
      end else begin
        hi = mid;
      end
    end
    chk(lo, 8'h07);
    chk(hi, 8'h08);
    wr(clm_pkg::SP_CFG, 2'h0, clm_pkg::IDX_CR2, 8'h00);
    $display("test search done");
  endtask

  // channel three: coef_b of 1.0 halves the mean of a constant 0x100 input
  task automatic t_band();
    coef_data = 32'h0000_4000;
    coef_ch = 2'h3;
    coef_we = 1'b1; // same set as tone two
    @(negedge clk);
    coef_we = 1'b0;
    wr(clm_pkg::SP_EXT, 2'h0, clm_pkg::IDX_THR, 8'h03);
    wr(clm_pkg::SP_CFG, 2'h3, clm_pkg::IDX_CR2, 8'h04); // channel two still metering
    wait_cyc(2 * MEAS + 8);
    rd(clm_pkg::SP_CFG, 2'h3, clm_pkg::IDX_CR2);
    chk(got, 8'h06);
    wr(clm_pkg::SP_EXT, 2'h0, clm_pkg::IDX_THR, 8'h05);
    wait_cyc(MEAS + 8);
    rd(clm_pkg::SP_CFG, 2'h3, clm_pkg::IDX_CR2);
    chk(got, 8'h04);
    $display("test band done");
  endtask

  // ************************************************
  // verdict
  // ************************************************
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    wait_cyc(12);
    rst = 1'b0;
    t_reset();
    t_regs();
    t_meter();
    t_loop();
    t_search();
    t_band();
    conclude();
  end
endmodule
